// *** src/rti_unit.sv ***
// Execution of interrupt, subroutine and literal returns
`timescale 1ns/1ps
module rti_unit
  import rti_pkg::*;
#(
  parameter int PCW = PC_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] phase,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic high_prio_active,
  input wire logic [PCW-1:0] stack_top_entry,
  input wire rti_regs_s shadow_regs,
  output logic busy,
  output logic flush,
  output logic stack_pop,
  output logic pc_load,
  output logic [PCW-1:0] pc_value,
  output logic regs_load,
  output rti_regs_s regs_value,
  output logic w_load,
  output logic [7:0] w_value,
  output logic high_prio_global_irq_enable_set,
  output logic low_prio_global_irq_enable_set,
  output logic flags_touched
);
  if (PCW < 1 || PCW > 32) begin : g_bad
    $error("PCW out of range");
  end

  logic rst_s1_reg, rst_n_reg;
  rti_dec_s dec;
  rti_dec_s held_reg;
  logic pop_now;
  logic flush_reg;
  logic take;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} rti_state_e;
  rti_state_e state_reg;

  // Assertion of resetn stays asynchronous; only its release is retimed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  rti_decoder rti_decoder_inst (
    .opcode(instr_word),
    .dec(dec)
  );

  // Decode is taken in Q1 only; the held copy drives the Q4 actions
  assign take = (state_reg == ST_IDLE) && instr_valid && (phase == PHASE_Q1)
    && (dec.kind != RTI_NONE);

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (phase == PHASE_Q4) begin
            state_reg <= ST_FLUSH; // RL12
          end
        end
        ST_FLUSH: begin
          if (phase == PHASE_Q4) begin
            state_reg <= ST_IDLE; // RL12
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      held_reg <= '0;
    end else if (take) begin
      held_reg <= dec;
    end
  end

  assign pop_now = (state_reg == ST_EXEC) && (phase == PHASE_Q4);

  // Pop and PC load share one Q4 pulse, so the stack and the PC
  // can never disagree about which entry was consumed
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= '0;
    end else begin
      stack_pop <= pop_now; // RL12
      pc_load <= pop_now; // RL5 RL8
      if (pop_now) begin
        pc_value <= stack_top_entry; // RL1 RL5 RL8
      end
    end
  end

  // Shadow restore only for the s form; s clear leaves them alone
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      regs_load <= 1'b0;
      regs_value <= '0;
    end else begin
      regs_load <= pop_now && held_reg.shadow
        && (held_reg.kind inside {RTI_INTR, RTI_SUB}); // RL9 RL11 RL2 RL10
      if (pop_now) begin
        regs_value <= shadow_regs;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      w_load <= 1'b0;
      w_value <= 8'h00;
    end else begin
      w_load <= pop_now && (held_reg.kind == RTI_LIT); // RL4
      if (pop_now) begin
        w_value <= held_reg.literal; // RL4
      end
    end
  end

  // Only one enable is set, so a low-priority return cannot
  // reopen high-priority interrupts by accident
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      high_prio_global_irq_enable_set <= 1'b0;
      low_prio_global_irq_enable_set <= 1'b0;
    end else begin
      high_prio_global_irq_enable_set <= pop_now && (held_reg.kind == RTI_INTR)
        && high_prio_active; // RL1
      low_prio_global_irq_enable_set <= pop_now && (held_reg.kind == RTI_INTR)
        && !high_prio_active; // RL1
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= (state_reg == ST_FLUSH) || pop_now; // RL12
    end
  end

  assign flush = flush_reg;
  assign busy = (state_reg != ST_IDLE);
  // No PC latch is ever written here; status flags change only through the s-form shadow restore
  assign flags_touched = 1'b0; // RL3 RL6 RL7

  a_pop_q4: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    stack_pop |-> $past(phase) == PHASE_Q4) // RL12
    else $error("pop outside Q4");
  a_pc_from_top: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    pc_load |-> pc_value == $past(stack_top_entry)) // RL8
    else $error("pc not loaded from stack top");
  a_lit_w: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    w_load |-> w_value == held_reg.literal && pc_load) // RL4
    else $error("literal not written with pop");
  a_no_shadow_s0: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (pc_load && !held_reg.shadow) |-> !regs_load) // RL10
    else $error("shadow restore with s clear");
  a_shadow_s1: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (pc_load && held_reg.shadow && held_reg.kind != RTI_LIT) |-> regs_load) // RL9
    else $error("shadow restore missing");
  a_gie_only_intr: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (high_prio_global_irq_enable_set || low_prio_global_irq_enable_set)
      |-> pc_load && held_reg.kind == RTI_INTR) // RL1
    else $error("enable set outside interrupt return");
  a_take_to_pop: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    take |-> ##[3:4] stack_pop) // RL3
    else $error("pop not in first cycle");
  a_flush_follows: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    stack_pop |-> flush [*4]) // RL12
    else $error("second cycle not flushed");

  // Whole-instruction timing and pairing of the pulses
  a_busy_span: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    take |=> busy [*7] ##1 !busy) // RL3
    else $error("return not two instruction cycles");
  a_pop_single: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    stack_pop |=> !stack_pop) // RL12
    else $error("stack popped twice");
  a_pop_with_pc: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    stack_pop |-> pc_load) // RL5
    else $error("pop without pc load");
  a_pc_with_pop: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    pc_load |-> stack_pop) // RL8
    else $error("pc load without pop");
  a_flush_end: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    stack_pop |-> ##5 !flush) // RL12
    else $error("flush overruns second cycle");
  a_gie_exclusive: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    !(high_prio_global_irq_enable_set && low_prio_global_irq_enable_set)) // RL1
    else $error("both enables set");
  a_gie_on_intr: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (pc_load && held_reg.kind == RTI_INTR)
      |-> (high_prio_global_irq_enable_set || low_prio_global_irq_enable_set)) // RL1
    else $error("interrupt return left enables alone");
  a_gie_priority: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    high_prio_global_irq_enable_set |-> $past(high_prio_active)) // RL1
    else $error("wrong enable priority");
  a_sub_no_irq: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (pc_load && held_reg.kind == RTI_SUB)
      |-> !(high_prio_global_irq_enable_set || low_prio_global_irq_enable_set)) // RL7
    else $error("subroutine return touched enables");
  a_lit_keeps_regs: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    w_load |-> !regs_load) // RL3
    else $error("literal return restored shadows");
  a_shadow_value: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    regs_load |-> regs_value == $past(shadow_regs)) // RL11
    else $error("shadow values not restored");
endmodule : rti_unit

// *** src/rti_pkg.sv ***
// Constants and carrier types for the return instruction unit
// How it works
// RL1: Interrupt return pops stack, sets global enable
// RL2: Interrupt return, s clear, keeps W/status/bank
// RL3: Literal return 0000 1100 kkkk kkkk, two cycles
// RL4: Literal return writes 8-bit literal into W
// RL5: Literal return pops top entry into PC
// RL6: PC latch registers never touched by returns
// RL7: Subroutine return 0000 0000 0001 001s, two cycles
// RL8: Subroutine return pops stack into PC
// RL9: Subroutine return, s set, restores shadows
// RL10: Subroutine return, s clear, keeps registers
// RL11: Interrupt return, s set, restores shadows
// RL12: Pop in fourth phase, second cycle flushed
package rti_pkg;
  localparam int PC_W = 21;
  localparam logic [15:0] RETI_MASK = 16'hFFFE;
  localparam logic [15:0] RETI_CODE = 16'h0010;
  localparam logic [15:0] RETS_MASK = 16'hFFFE;
  localparam logic [15:0] RETS_CODE = 16'h0012;
  localparam logic [15:0] RETL_MASK = 16'hFF00;
  localparam logic [15:0] RETL_CODE = 16'h0C00;
  localparam int SHADOW_BIT = 0;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] PHASE_Q1 = 2'h0;

  typedef enum logic [1:0] {RTI_NONE, RTI_INTR, RTI_SUB, RTI_LIT} rti_kind_e;

  typedef struct packed {
    rti_kind_e kind;
    logic shadow;
    logic [7:0] literal;
  } rti_dec_s;

  typedef struct packed {
    logic [7:0] working;
    logic [7:0] flags;
    logic [7:0] bank;
  } rti_regs_s;
endpackage : rti_pkg

// *** src/rti_decoder.sv ***
// Opcode decoder for the three return instructions
`timescale 1ns/1ps
module rti_decoder
  import rti_pkg::*;
(
  input wire logic [15:0] opcode,
  output rti_dec_s dec
);
  always_comb begin
    dec.kind = RTI_NONE;
    dec.shadow = opcode[SHADOW_BIT];
    dec.literal = opcode[7:0];
    if ((opcode & RETI_MASK) == RETI_CODE) begin
      dec.kind = RTI_INTR; // RL1
    end else if ((opcode & RETS_MASK) == RETS_CODE) begin
      dec.kind = RTI_SUB; // RL7
    end else if ((opcode & RETL_MASK) == RETL_CODE) begin
      dec.kind = RTI_LIT; // RL3
    end
  end
endmodule : rti_decoder

// *** test/rti_unit_tb.sv ***
// Self-checking bench for the return instruction unit
`timescale 1ns/1ps
module rti_unit_tb;
  import rti_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] phase = 2'h0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic hp = 1'b0;
  logic [20:0] top = 21'h000000;
  rti_regs_s sh = 24'h000000;
  logic busy, flush, pop, pcl, rl, wl, ghi, glo, ft;
  logic [20:0] pcv;
  rti_regs_s rv;
  logic [7:0] wv;
  int failures = 0;
  int n_compared = 0;
  rti_unit rti_unit_inst (.core_clk(core_clk), .resetn(resetn), .phase(phase),
    .instr_valid(instr_valid), .instr_word(instr_word), .high_prio_active(hp),
    .stack_top_entry(top), .shadow_regs(sh), .busy(busy), .flush(flush),
    .stack_pop(pop), .pc_load(pcl), .pc_value(pcv), .regs_load(rl), .regs_value(rv),
    .w_load(wl), .w_value(wv), .high_prio_global_irq_enable_set(ghi),
    .low_prio_global_irq_enable_set(glo), .flags_touched(ft));
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) phase <= phase + 2'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // Offers op so that it is taken on the next Q1 edge, returns once flush ends
  task automatic run_ret(input logic [15:0] op, input logic [20:0] t, input logic h,
      input rti_regs_s s, input logic [4:0] e, input logic [7:0] ew);
    @(posedge core_clk);
    top <= t;
    hp <= h;
    sh <= s;
    while (phase !== 2'h3) @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= op;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(busy, e[4]);
    chk(pop, 1'b0);
    @(posedge core_clk);
    #1;
    chk({pop, wl, rl, ghi, glo}, e);
    chk({pcl, ft, flush}, {e[4], 1'b0, e[4]});
    if (e[4]) chk(pcv, t);
    if (e[3]) chk(wv, ew);
    if (e[2]) chk(rv, s);
    @(posedge core_clk);
    #1;
    chk({pop, wl, rl, ghi, glo}, 5'h00);
    chk(flush, e[4]);
    repeat (2) @(posedge core_clk);
    #1;
    chk(busy, e[4]);
    @(posedge core_clk);
    #1;
    chk(busy, 1'b0);
    chk(flush, e[4]);
    @(posedge core_clk);
    #1;
    chk(flush, 1'b0);
  endtask : run_ret
  task automatic t_intr;
    run_ret(16'h0010, 21'h1ABCDE, 1'b1, 24'hA5C35A, 5'h12, 8'h00);
    run_ret(16'h0011, 21'h000001, 1'b0, 24'h3C96E1, 5'h15, 8'h00);
  endtask : t_intr
  task automatic t_sub;
    run_ret(16'h0012, 21'h1FFFFF, 1'b1, 24'h123456, 5'h10, 8'h00);
    run_ret(16'h0013, 21'h0F0F0F, 1'b0, 24'hFEDCBA, 5'h14, 8'h00);
  endtask : t_sub
  task automatic t_lit;
    run_ret(16'h0C00, 21'h155555, 1'b1, 24'h777777, 5'h18, 8'h00);
    run_ret(16'h0CFF, 21'h0AAAAA, 1'b0, 24'h888888, 5'h18, 8'hFF);
  endtask : t_lit
  // Neighbours of the return patterns must be ignored
  task automatic t_refuse;
    run_ret(16'h0014, 21'h1ABCDE, 1'b1, 24'hA5C35A, 5'h00, 8'h00);
    run_ret(16'h0D12, 21'h1ABCDE, 1'b0, 24'hA5C35A, 5'h00, 8'h00);
  endtask : t_refuse
  // A return offered again while the first still runs is ignored
  task automatic t_busy;
    @(posedge core_clk);
    while (phase !== 2'h3) @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= 16'h0012;
    @(posedge core_clk);
    instr_word <= 16'h0C55;
    repeat (4) @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    chk({pop, busy}, 2'h1);
    repeat (4) @(posedge core_clk);
    #1;
    chk({pop, wl, busy}, 3'h0);
  endtask : t_busy
  // Reset in mid-instruction drops the return with no pulse left behind
  task automatic t_reset;
    @(posedge core_clk);
    while (phase !== 2'h3) @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= 16'h0C3C;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    chk(busy, 1'b1);
    @(posedge core_clk);
    resetn <= 1'b0;
    #1;
    chk({busy, pop, wl}, 3'h0);
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk({busy, pop, wl, flush}, 4'h0);
  endtask : t_reset
  initial begin
    #200000;
    failures++;
    finish_test;
  end
  initial begin
    repeat (7) @(posedge core_clk);
    #1;
    chk({pop, busy, flush, wl}, 4'h0);
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_intr;
    t_sub;
    t_busy;
    t_reset;
    t_lit;
    t_refuse;
    finish_test;
  end
endmodule : rti_unit_tb
